// ### core/dlpi_top.sv
`timescale 1ns/100ps
// Contract
// - each link clock delivers one odd and one even pixel together
// - odd pixel comes first on a line, even pixel second
// - mapping strap low selects JEIDA, high or open selects VESA
// - each primary is an unsigned 8-bit code, larger means brighter
// - bit 7 is the colour MSB and bit 0 the LSB for r, g, b
// - logic 1 is high level; all zeros black, all ones white
// - line and frame timing come from data enable alone, no syncs
// - frame-rate select input tells 50 Hz from 60 Hz timing
module dlpi_top
    import dlpi_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // odd-pixel link, deserialised slots per lane
    input wire dlpi_lanes_t odd_link_lanes_p,
    input wire logic odd_link_clock_p,
    // even-pixel link
    input wire dlpi_lanes_t even_link_lanes_p,
    input wire logic even_link_clock_p,
    // straps
    input wire logic bit_mapping_select_alt,
    input wire logic frame_rate_select,
    // pixel pair stream
    output dlpi_pair_t pixel_pair,
    output logic pixel_valid,
    input wire logic pixel_ready,
    // status
    output logic rate_sixty_mode,
    output logic vesa_mapping,
    output logic line_len_error,
    output logic overflow
);
    logic [SYNC_W-1:0] sync1_q;
    logic [SYNC_W-1:0] sync2_q;
    logic [SYNC_W-1:0] pins;
    dlpi_lanes_t odd_s;
    dlpi_lanes_t even_s;
    dlpi_rgb_t odd_dec;
    dlpi_rgb_t even_dec;
    logic odd_link_clock_p_prev_q;
    logic link_edge;
    logic de;
    logic de_prev_q;
    logic vesa_q;
    logic rate_q;
    logic [CNT_W-1:0] gap_q;
    logic [CNT_W-1:0] act_q;
    dlpi_pair_t cap_q;
    logic cap_v_q;
    logic buf_ready;
    logic accept;
    logic len_err_q;
    logic ovf_q;
    dlpi_pair_t buf_data;
    logic buf_valid;

    function automatic dlpi_rgb_t decode(dlpi_lanes_t l, logic vesa);
        dlpi_rgb_t c;
        if (vesa) begin
            c.r = {l.lane3[1:0], l.lane0[5:0]};
            c.g = {l.lane3[3:2], l.lane1[4:0], l.lane0[6]};
            c.b = {l.lane3[5:4], l.lane2[3:0], l.lane1[6:5]};
        end else begin
            c.r = {l.lane0[5:0], l.lane3[1:0]};
            c.g = {l.lane1[4:0], l.lane0[6], l.lane3[3:2]};
            c.b = {l.lane2[3:0], l.lane1[6:5], l.lane3[5:4]};
        end
        return c;
    endfunction : decode

    assign pins = {odd_link_lanes_p, even_link_lanes_p, odd_link_clock_p,
                   even_link_clock_p, bit_mapping_select_alt,
                   frame_rate_select};

    // two-stage synchroniser for every pin
    // strap stages reset high so the modes hold their reset level until
    // the pin values arrive
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            sync1_q <= {{(SYNC_W-2){RESET_BIT}}, SEL_HIGH, SEL_HIGH};
            sync2_q <= {{(SYNC_W-2){RESET_BIT}}, SEL_HIGH, SEL_HIGH};
        end else begin
            sync1_q <= pins;
            sync2_q <= sync1_q;
        end
    end

    assign odd_s = sync2_q[SY_ODD +: 4*SLOT_W];
    assign even_s = sync2_q[SY_EVEN +: 4*SLOT_W];
    assign link_edge = sync2_q[SY_ODD_LINK_CLOCK_P] & ~odd_link_clock_p_prev_q;
    assign de = odd_s.lane2[DE_SLOT];

    // straps follow the pins; an open pin is pulled high on the board
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            vesa_q <= SEL_HIGH;
            rate_q <= SEL_HIGH;
        end else begin
            vesa_q <= sync2_q[SY_MAP];
            rate_q <= sync2_q[SY_RATE];
        end
    end

    // colour codes kept unsigned, msb first, level true
    assign odd_dec = decode(odd_s, vesa_q);
    assign even_dec = decode(even_s, vesa_q);

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            odd_link_clock_p_prev_q <= RESET_BIT;
        end else begin
            odd_link_clock_p_prev_q <= sync2_q[SY_ODD_LINK_CLOCK_P];
        end
    end

    // line and frame tracking from data enable alone
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            de_prev_q <= RESET_BIT;
            gap_q <= CNT_SAT;
            act_q <= '0;
            len_err_q <= RESET_BIT;
        end else begin
            len_err_q <= RESET_BIT;
            if (link_edge) begin
                de_prev_q <= de;
                if (de) begin
                    gap_q <= '0;
                    if (!de_prev_q) begin
                        act_q <= CNT_ONE;
                    end else if (act_q != CNT_SAT) begin
                        act_q <= act_q + CNT_ONE;
                    end
                end else begin
                    if (gap_q != CNT_SAT) begin
                        gap_q <= gap_q + CNT_ONE;
                    end
                    if (de_prev_q) begin
                        len_err_q <= (act_q != ACTIVE_CLOCKS);
                    end
                end
            end
        end
    end

    // both pixels of a link period are taken on the same edge
    assign accept = link_edge & de & (~cap_v_q | buf_ready);

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            cap_q <= '0;
            cap_v_q <= RESET_BIT;
        end else begin
            if (accept) begin
                cap_q.odd_px <= odd_dec;
                cap_q.even_px <= even_dec;
                cap_q.first_of_line <= ~de_prev_q;
                cap_q.first_of_frame <= ~de_prev_q &
                                        (gap_q > LINE_TOTAL_MAX);
            end
            cap_v_q <= accept | (cap_v_q & ~buf_ready);
        end
    end

    // a pair lost to a stalled drain is flagged until reset
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            ovf_q <= RESET_BIT;
        end else if (link_edge && de && cap_v_q && !buf_ready) begin
            ovf_q <= 1'h1;
        end
    end

    dlpi_buf #(.W($bits(dlpi_pair_t))) u_buf (
        .clock(clock),
        .rst_b(rst_b),
        .in_valid(cap_v_q),
        .in_data(cap_q),
        .in_ready(buf_ready),
        .out_valid(buf_valid),
        .out_data(buf_data),
        .out_ready(pixel_ready)
    );

    assign pixel_pair = buf_data;
    assign pixel_valid = buf_valid;
    assign rate_sixty_mode = rate_q;
    assign vesa_mapping = vesa_q;
    assign line_len_error = len_err_q;
    assign overflow = ovf_q;

    capture_pair_a: assert property (
        @(posedge clock) disable iff (!rst_b)
        accept |=> cap_v_q && cap_q.odd_px == $past(odd_dec))
        else $error("odd pixel not captured on link edge");

    pair_order_a: assert property (
        @(posedge clock) disable iff (!rst_b)
        accept |=> cap_q.even_px == $past(even_dec))
        else $error("even pixel not in second position");

    mapping_strap_a: assert property (
        @(posedge clock) disable iff (!rst_b)
        ##3 vesa_q == $past(bit_mapping_select_alt, 3))
        else $error("mapping select does not follow strap");

    color_msb_a: assert property (
        @(posedge clock) disable iff (!rst_b)
        vesa_q |-> odd_dec.r[COLOR_MSB] == odd_s.lane3[1]
                   && odd_dec.b[COLOR_LSB] == odd_s.lane1[5])
        else $error("colour bit order wrong");

    intensity_code_a: assert property (
        @(posedge clock) disable iff (!rst_b)
        !vesa_q |-> odd_dec.g == {odd_s.lane1[4:0], odd_s.lane0[6],
                                  odd_s.lane3[3:2]})
        else $error("green code order wrong");

    white_level_a: assert property (
        @(posedge clock) disable iff (!rst_b)
        (odd_s[4*SLOT_W-2:0] == '1) |-> odd_dec == '1)
        else $error("all ones does not decode to white");

    de_only_line_a: assert property (
        @(posedge clock) disable iff (!rst_b)
        accept && !de_prev_q |=> cap_q.first_of_line)
        else $error("line start missed on data enable rise");

    frame_start_a: assert property (
        @(posedge clock) disable iff (!rst_b)
        accept && !de_prev_q && gap_q > LINE_TOTAL_MAX
        |=> cap_q.first_of_frame && cap_q.first_of_line)
        else $error("frame start missed after long gap");

    mid_line_a: assert property (
        @(posedge clock) disable iff (!rst_b)
        accept && de_prev_q |=> !cap_q.first_of_line && !cap_q.first_of_frame)
        else $error("spurious line start inside line");

    de_slot_a: assert property (
        @(posedge clock) disable iff (!rst_b)
        link_edge |=> de_prev_q == $past(odd_s.lane2[DE_SLOT]))
        else $error("data enable not taken from its slot");

    rate_select_a: assert property (
        @(posedge clock) disable iff (!rst_b)
        ##3 rate_sixty_mode == $past(frame_rate_select, 3))
        else $error("rate mode does not follow select pin");
endmodule : dlpi_top

// ### core/dlpi_pkg.sv
package dlpi_pkg;
    // lane slot layout inside one link clock period
    localparam int SLOT_W = 7;
    localparam int DE_SLOT = 6;
    localparam int COLOR_W = 8;
    localparam int COLOR_MSB = 7;
    localparam int COLOR_LSB = 0;

    // data-enable timing, in link clock periods
    localparam int CNT_W = 12;
    localparam logic [CNT_W-1:0] ACTIVE_CLOCKS = 12'h3c0;
    localparam logic [CNT_W-1:0] LINE_TOTAL_MAX = 12'h47e;
    localparam logic [CNT_W-1:0] CNT_SAT = 12'hfff;
    localparam logic [CNT_W-1:0] CNT_ONE = 12'h001;

    // synchroniser vector: both links, both clocks, two straps
    localparam int SYNC_W = 4 * SLOT_W * 2 + 4;
    localparam int SY_RATE = 0;
    localparam int SY_MAP = 1;
    localparam int SY_EVEN_LINK_CLOCK_P = 2;
    localparam int SY_ODD_LINK_CLOCK_P = 3;
    localparam int SY_EVEN = 4;
    localparam int SY_ODD = 4 + 4 * SLOT_W;

    localparam logic RESET_BIT = 1'h0;
    localparam logic SEL_HIGH = 1'h1;

    typedef struct packed {
        logic [SLOT_W-1:0] lane3;
        logic [SLOT_W-1:0] lane2;
        logic [SLOT_W-1:0] lane1;
        logic [SLOT_W-1:0] lane0;
    } dlpi_lanes_t;

    typedef struct packed {
        logic [COLOR_W-1:0] r;
        logic [COLOR_W-1:0] g;
        logic [COLOR_W-1:0] b;
    } dlpi_rgb_t;

    typedef struct packed {
        logic first_of_frame;
        logic first_of_line;
        dlpi_rgb_t odd_px;
        dlpi_rgb_t even_px;
    } dlpi_pair_t;
endpackage : dlpi_pkg

// ### core/dlpi_buf.sv
`timescale 1ns/100ps
module dlpi_buf
    import dlpi_pkg::*;
#(
    parameter int W = $bits(dlpi_pair_t)
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // filling side
    input wire logic in_valid,
    input wire logic [W-1:0] in_data,
    output logic in_ready,
    // draining side
    output logic out_valid,
    output logic [W-1:0] out_data,
    input wire logic out_ready
);
    logic [W-1:0] head_q;
    logic [W-1:0] spare_q;
    logic head_v_q;
    logic spare_v_q;
    logic pop;
    logic push;
    logic head_free;

    assign in_ready = ~spare_v_q;
    assign pop = head_v_q & out_ready;
    assign push = in_valid & ~spare_v_q;
    assign head_free = pop | ~head_v_q;
    assign out_valid = head_v_q;
    assign out_data = head_q;

    // head entry feeds the output directly
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            head_v_q <= RESET_BIT;
            head_q <= '0;
        end else if (head_free) begin
            head_v_q <= spare_v_q | push;
            head_q <= spare_v_q ? spare_q : in_data;
        end
    end

    // spare entry catches a word while the drain stalls
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            spare_v_q <= RESET_BIT;
            spare_q <= '0;
        end else if (push && !head_free) begin
            spare_v_q <= 1'h1;
            spare_q <= in_data;
        end else if (head_free) begin
            spare_v_q <= RESET_BIT;
        end
    end
endmodule : dlpi_buf

// ### tb/dlpi_tx_model.sv
`timescale 1ns/100ps
module dlpi_tx_model
    import dlpi_pkg::*;
(
    // no-connection positions have no port
    // odd-pixel link
    output dlpi_lanes_t odd_link_lanes_p,
    output logic odd_link_clock_p,
    // even-pixel link
    output dlpi_lanes_t even_link_lanes_p,
    output logic even_link_clock_p
);
    // slot packing; jeida is the vesa layout with each colour rotated
    function automatic dlpi_lanes_t pack(dlpi_rgb_t p, logic de, logic jd);
        dlpi_lanes_t l;
        dlpi_rgb_t q;
        q = p;
        if (jd) begin
            q.r = {p.r[1:0], p.r[7:2]};
            q.g = {p.g[1:0], p.g[7:2]};
            q.b = {p.b[1:0], p.b[7:2]};
        end
        l.lane0 = {q.g[0], q.r[5:0]};
        l.lane1 = {q.b[1:0], q.g[5:1]};
        l.lane2 = {de, 2'h0, q.b[5:2]};
        l.lane3 = {1'h0, q.b[7:6], q.g[7:6], q.r[7:6]};
        return l;
    endfunction : pack

    // one link period, both links together, odd first on the line
    task automatic send(dlpi_rgb_t o, dlpi_rgb_t e, logic de, logic jd);
        odd_link_lanes_p = pack(o, de, jd);
        even_link_lanes_p = pack(e, de, jd);
        // link period slowed for 20 MHz sampling
        #200;
        odd_link_clock_p = 1'h1;
        even_link_clock_p = 1'h1;
        #200;
        odd_link_clock_p = 1'h0;
        even_link_clock_p = 1'h0;
    endtask : send

    // clock stands still between lines, lanes show a changed pattern
    task automatic idle();
        odd_link_lanes_p = ~odd_link_lanes_p;
        even_link_lanes_p = ~even_link_lanes_p;
    endtask : idle

    initial begin
        odd_link_lanes_p = '0;
        even_link_lanes_p = '0;
        odd_link_clock_p = 1'h0;
        even_link_clock_p = 1'h0;
    end
endmodule : dlpi_tx_model

// ### tb/tb_top.sv
`timescale 1ns/100ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin failures++; \
    $display("ERROR t=%0t got %0h exp %0h", $time, (g), (e)); end end
module tb_top
    import dlpi_pkg::*;
;
    logic clock, rst_b, map_sel, rate_sel, pixel_ready, sink_en;
    logic pixel_valid, rate_sixty_mode, vesa_mapping, line_len_error, overflow;
    dlpi_lanes_t odd_l, even_l;
    logic odd_c, even_c;
    dlpi_pair_t pixel_pair;
    dlpi_pair_t got[$], exp[$];
    int failures = 0, total_checks = 0, len_errs = 0;

    dlpi_tx_model i_tx (.odd_link_lanes_p(odd_l), .odd_link_clock_p(odd_c),
        .even_link_lanes_p(even_l), .even_link_clock_p(even_c));
    dlpi_top i_dut (.clock(clock), .rst_b(rst_b), .odd_link_lanes_p(odd_l),
        .odd_link_clock_p(odd_c), .even_link_lanes_p(even_l),
        .even_link_clock_p(even_c), .bit_mapping_select_alt(map_sel),
        .frame_rate_select(rate_sel), .pixel_pair(pixel_pair),
        .pixel_valid(pixel_valid), .pixel_ready(pixel_ready),
        .rate_sixty_mode(rate_sixty_mode), .vesa_mapping(vesa_mapping),
        .line_len_error(line_len_error), .overflow(overflow));

    initial begin
        clock = 1'h0;
        forever #25 clock = ~clock;
    end
    always @(posedge clock) begin
        pixel_ready <= sink_en;
        if (pixel_valid === 1'h1 && pixel_ready === 1'h1)
            got.push_back(pixel_pair);
        if (line_len_error === 1'h1)
            len_errs++;
    end

    // pair 0 is black odd, white even
    function automatic dlpi_rgb_t px(int n);
        return (n == 1) ? 24'hffffff : 24'(n * 24'h0b0705);
    endfunction : px

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : tally_and_finish

    task automatic send_line(int n, int blank, logic ff, logic jd, int keep);
        @(posedge clock);
        #13;
        for (int i = 0; i < n; i++) begin
            if (i < keep)
                exp.push_back('{ff && i == 0, i == 0, px(2 * i),
                                px(2 * i + 1)});
            i_tx.send(px(2 * i), px(2 * i + 1), 1'h1, jd);
        end
        for (int i = 0; i < blank; i++)
            i_tx.send(24'h0, 24'h0, 1'h0, jd);
        i_tx.idle();
    endtask : send_line

    task automatic drain_and_compare();
        int k;
        k = 0;
        while (got.size() < exp.size() && k < 500) begin
            @(posedge clock);
            k++;
        end
        if (got.size() < exp.size()) begin
            failures++;
            $display("ERROR t=%0t stream timed out", $time);
            tally_and_finish();
        end else begin
            repeat (4) @(posedge clock);
            `CHK(got.size(), exp.size())
            foreach (exp[i])
                `CHK(got[i], exp[i])
            got.delete();
            exp.delete();
        end
    endtask : drain_and_compare

    task automatic t_straps();
        rate_sel <= 1'h0;
        repeat (4) @(posedge clock);
        `CHK(rate_sixty_mode, 1'h0)
        `CHK(vesa_mapping, 1'h1)
        rate_sel <= 1'h1;
        repeat (4) @(posedge clock);
        `CHK(rate_sixty_mode, 1'h1)
        $display("straps done");
    endtask : t_straps

    task automatic t_full_line();
        send_line(960, 140, 1'h1, 1'h0, 960);
        drain_and_compare();
        `CHK(len_errs, 0)
        $display("full vesa line done");
    endtask : t_full_line

    task automatic t_short_jeida();
        map_sel <= 1'h0;
        repeat (4) @(posedge clock);
        `CHK(vesa_mapping, 1'h0)
        send_line(5, 4, 1'h0, 1'h1, 5);
        drain_and_compare();
        `CHK(len_errs, 1)
        $display("short jeida line done");
    endtask : t_short_jeida

    task automatic t_stall();
        `CHK(overflow, 1'h0)
        sink_en <= 1'h0;
        send_line(5, 4, 1'h0, 1'h1, 3);
        `CHK(pixel_valid, 1'h1)
        `CHK(overflow, 1'h1)
        `CHK(got.size(), 0)
        sink_en <= 1'h1;
        drain_and_compare();
        `CHK(pixel_valid, 1'h0)
        `CHK(overflow, 1'h1)
        `CHK(len_errs, 2)
        $display("stall and overflow done");
    endtask : t_stall

    // blank run longer than a line total, then a line that opens a frame
    task automatic t_new_frame();
        send_line(2, 1152, 1'h0, 1'h1, 2);
        send_line(2, 4, 1'h1, 1'h1, 2);
        drain_and_compare();
        `CHK(len_errs, 4)
        $display("frame start after long gap done");
    endtask : t_new_frame

    initial begin
        rst_b = 1'h0;
        map_sel = 1'h1;
        rate_sel = 1'h1;
        sink_en = 1'h1;
        repeat (4) @(posedge clock);
        rst_b <= 1'h1;
        t_straps();
        t_full_line();
        t_short_jeida();
        t_stall();
        t_new_frame();
        tally_and_finish();
    end
endmodule : tb_top
